// ---- rtl/upis_top.sv ----
// Purpose: protocol interrupt enable and status of an async serial unit
// Assumes: rx and cts pins are asynchronous; register port on clk
// Notes: includes a small receiver and auto-baud detector feeding flags
`timescale 1ns/1ps
`default_nettype none
module upis_top
  import upis_pkg::*;
(
  input wire logic clk, // 50 MHz clock
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic [ADDR_W-1:0] reg_addr, // register byte address
  input wire logic [DATA_W-1:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [DATA_W-1:0] reg_rdata, // read data, cycle after reg_rd
  input wire logic rx_pin, // serial receive line
  input wire logic cts_pin, // clear-to-send pin
  output logic irq // protocol interrupt, level
);

  upis_state_t st;
  upis_state_t nxt;
  logic rx_fall;
  logic tick;
  logic stop_bad;
  logic par_bad;
  logic brk_evt;
  logic ab_fall_evt;
  logic ab_ovf_evt;
  logic sts_wr;
  logic [31:0] clr;
  logic ls_clr;
  logic [15:0] brk_lim;
  logic [3:0] frame_bits;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a,
                                          input upis_state_t s);
    logic [31:0] w;
    w = RST_WORD;
    if (hit(a, OFF_IRQ_EN))
    begin
      w[EN_LS_BIT] = s.en_ls;
      w[EN_AB_BIT] = s.en_ab;
    end
    else if (hit(a, OFF_STATUS))
    begin
      w[ST_CTS_PIN] = s.cts_lvl;
      w[ST_CTS_SYNC] = s.cts_sync;
      w[ST_AB_ERR] = s.ab_err;
      w[ST_BUSY] = (s.rx_state != RX_IDLE);
      w[ST_AB_DONE] = s.ab_done;
      w[ST_BREAK] = s.brk;
      w[ST_FRM] = s.frm;
      w[ST_PAR] = s.par;
    end
    else if (hit(a, OFF_CTRL))
    begin
      w[CTL_STOP2] = s.stop2;
      w[CTL_PAR_EN] = s.par_en;
      w[CTL_EVEN] = s.even;
      w[CTL_AB_EN] = s.ab_en;
    end
    else if (hit(a, OFF_BAUD))
    begin
      w[BAUD_DIV_LSB +: BAUD_DIV_W] = s.baud_div;
    end
    rd_word = w;
  endfunction

  always_comb
  begin
    nxt = st;
    rx_fall = st.rx_prev & ~st.rx_s2;
    tick = (st.tick_cnt == 11'h000);
    stop_bad = 1'b0;
    par_bad = 1'b0;
    ab_fall_evt = 1'b0;
    ab_ovf_evt = 1'b0;
    frame_bits = BASE_FRAME_BITS + {3'h0, st.par_en} + {3'h0, st.stop2};
    brk_lim = 16'(frame_bits) * (16'(st.baud_div) + 16'h0001);
    brk_evt = ~st.rx_s2 & (st.low_cnt == brk_lim);
    sts_wr = reg_wr & (hit(reg_addr, OFF_STATUS) | hit(reg_addr, OFF_IRQ_CLR));
    clr = sts_wr ? reg_wdata : RST_WORD;
    ls_clr = clr[ST_BREAK] | clr[ST_FRM] | clr[ST_PAR];

    // pin synchronisers; first stage feeds only the second
    nxt.rx_s1 = rx_pin;
    nxt.rx_s2 = st.rx_s1;
    nxt.rx_prev = st.rx_s2;
    nxt.cts_s1 = cts_pin;
    nxt.cts_lvl = st.cts_s1;
    nxt.cts_sync = st.cts_lvl;

    // software writes
    if (reg_wr && hit(reg_addr, OFF_IRQ_EN))
    begin
      nxt.en_ls = reg_wdata[EN_LS_BIT];
      nxt.en_ab = reg_wdata[EN_AB_BIT];
    end
    if (reg_wr && hit(reg_addr, OFF_CTRL))
    begin
      nxt.stop2 = reg_wdata[CTL_STOP2];
      nxt.par_en = reg_wdata[CTL_PAR_EN];
      nxt.even = reg_wdata[CTL_EVEN];
      nxt.ab_en = reg_wdata[CTL_AB_EN];
    end
    if (reg_wr && hit(reg_addr, OFF_BAUD))
    begin
      nxt.baud_div = reg_wdata[BAUD_DIV_LSB +: BAUD_DIV_W];
    end

    // receiver: bit period is baud_div + 1 cycles, mid-bit sampling
    nxt.tick_cnt = tick ? {1'b0, st.baud_div} : st.tick_cnt - 11'h001;
    case (st.rx_state)
      RX_IDLE:
      begin
        if (rx_fall && st.ab_state == AB_IDLE)
        begin
          nxt.rx_state = RX_START;
          nxt.tick_cnt = {2'b00, st.baud_div[BAUD_DIV_W-1:1]};
        end
      end
      RX_START:
      begin
        if (tick)
        begin
          nxt.rx_state = st.rx_s2 ? RX_IDLE : RX_DATA;
          nxt.bit_cnt = 3'h0;
          nxt.par_acc = 1'b0;
        end
      end
      RX_DATA:
      begin
        if (tick)
        begin
          nxt.par_acc = st.par_acc ^ st.rx_s2;
          nxt.bit_cnt = st.bit_cnt + 3'h1;
          if (st.bit_cnt == DATA_LAST)
          begin
            nxt.rx_state = st.par_en ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR:
      begin
        if (tick)
        begin
          par_bad = st.even ? (st.par_acc ^ st.rx_s2)
                            : ~(st.par_acc ^ st.rx_s2);
          nxt.rx_state = RX_STOP;
        end
      end
      RX_STOP:
      begin
        if (tick)
        begin
          stop_bad = ~st.rx_s2;
          nxt.rx_state = st.stop2 ? RX_STOP2 : RX_IDLE;
        end
      end
      RX_STOP2:
      begin
        if (tick)
        begin
          nxt.rx_state = RX_IDLE;
        end
      end
      default:
      begin
        nxt.rx_state = RX_IDLE;
      end
    endcase

    // low-time counter for break detection, saturating
    if (st.rx_s2)
    begin
      nxt.low_cnt = 16'h0000;
    end
    else if (st.low_cnt != 16'hFFFF)
    begin
      nxt.low_cnt = st.low_cnt + 16'h0001;
    end

    // auto-baud: time between falling edges of a 0x55 pattern
    case (st.ab_state)
      AB_IDLE:
      begin
        if (st.ab_en)
        begin
          nxt.ab_state = AB_ARM;
        end
      end
      AB_ARM:
      begin
        nxt.ab_cnt = '0;
        nxt.ab_num = 3'h0;
        if (!st.ab_en)
        begin
          nxt.ab_state = AB_IDLE;
        end
        else if (rx_fall)
        begin
          nxt.ab_state = AB_MEAS;
        end
      end
      AB_MEAS:
      begin
        nxt.ab_cnt = st.ab_cnt + AB_CNT_W'(1);
        if (!st.ab_en)
        begin
          nxt.ab_state = AB_IDLE;
        end
        else if (st.ab_cnt == '1)
        begin
          ab_ovf_evt = 1'b1;
          nxt.ab_en = 1'b0;
          nxt.ab_state = AB_IDLE;
        end
        else if (rx_fall)
        begin
          ab_fall_evt = 1'b1;
          nxt.ab_cnt = '0;
          nxt.ab_num = st.ab_num + 3'h1;
          if (st.ab_num == AB_LAST_INTERVAL)
          begin
            nxt.baud_div = st.ab_cnt[BAUD_DIV_W:1];
            nxt.ab_en = 1'b0;
            nxt.ab_state = AB_IDLE;
          end
        end
      end
      default:
      begin
        nxt.ab_state = AB_IDLE;
      end
    endcase

    // sticky flags: a set in the clearing cycle wins
    nxt.brk = (st.brk & ~ls_clr) | brk_evt;
    nxt.frm = (st.frm & ~ls_clr) | stop_bad;
    nxt.par = (st.par & ~ls_clr) | par_bad;
    nxt.ab_done = (st.ab_done & ~clr[ST_AB_DONE])
                  | ab_fall_evt | ab_ovf_evt;
    nxt.ab_err = (st.ab_err & ~(clr[ST_AB_DONE] | clr[ST_AB_ERR]))
                 | ab_ovf_evt;

    nxt.rdata_ff = reg_rd ? rd_word(reg_addr, st) : RST_WORD;
    nxt.irq_ff = ((nxt.brk | nxt.frm | nxt.par) & nxt.en_ls)
                 | (nxt.ab_done & nxt.en_ab);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
      st.rx_s1 <= 1'b1;
      st.rx_s2 <= 1'b1;
      st.rx_prev <= 1'b1;
      st.baud_div <= RST_BAUD_DIV;
      st.rx_state <= RX_IDLE;
      st.ab_state <= AB_IDLE;
    end
    else if (ce)
    begin
      st <= nxt;
    end
  end

  assign reg_rdata = st.rdata_ff;
  assign irq = st.irq_ff;

  sequence ab_overrun_s;
    ce && ab_ovf_evt;
  endsequence

  sequence ab_clear_s;
    ce && sts_wr && (reg_wdata[ST_AB_DONE] || reg_wdata[ST_AB_ERR])
      && !ab_ovf_evt;
  endsequence

  sequence ls_clear_s;
    ce && ls_clr && !brk_evt && !stop_bad && !par_bad;
  endsequence

  ls_irq_a: assert property (@(posedge clk) disable iff (rst)
    st.irq_ff |-> ((st.brk || st.frm || st.par) && st.en_ls)
                  || (st.ab_done && st.en_ab))
    else $error("interrupt high without an enabled source");

  ab_mask_a: assert property (@(posedge clk) disable iff (rst)
    (!st.en_ab && !st.en_ls) |-> !st.irq_ff)
    else $error("interrupt high with both enables clear");

  cts_pin_a: assert property (@(posedge clk) disable iff (rst)
    ce [*3] |-> (st.cts_lvl == $past(cts_pin, 2)))
    else $error("cts pin level bit lags wrongly");

  cts_sync_a: assert property (@(posedge clk) disable iff (rst)
    ce [*2] |-> (st.cts_sync == $past(st.cts_lvl)))
    else $error("cts synced bit does not follow the pin level");

  ab_err_a: assert property (@(posedge clk) disable iff (rst)
    ab_overrun_s |=> (st.ab_err && st.ab_done && !st.ab_en))
    else $error("overrun did not raise error and done together");

  ab_clr_a: assert property (@(posedge clk) disable iff (rst)
    ab_clear_s |=> !st.ab_err)
    else $error("auto-baud error flag not cleared by write");

  done_clr_a: assert property (@(posedge clk) disable iff (rst)
    (ab_clear_s and (reg_wdata[ST_AB_DONE] && !ab_fall_evt))
      |=> !st.ab_done)
    else $error("auto-baud done flag not cleared by write");

  busy_rd_a: assert property (@(posedge clk) disable iff (rst)
    (ce && reg_rd && hit(reg_addr, OFF_STATUS))
      |=> (st.rdata_ff[ST_BUSY] == ($past(st.rx_state) != RX_IDLE)))
    else $error("busy bit does not match receiver state");

  ab_done_a: assert property (@(posedge clk) disable iff (rst)
    (ce && ab_fall_evt) |=> st.ab_done ##0 (!st.ab_err || $past(st.ab_err)))
    else $error("auto-baud done flag not set after interval");

  brk_a: assert property (@(posedge clk) disable iff (rst)
    (ce && brk_evt) |=> st.brk)
    else $error("break flag not set after long low time");

  frm_a: assert property (@(posedge clk) disable iff (rst)
    (ce && st.rx_state == RX_STOP && tick && !st.rx_s2) |=> st.frm)
    else $error("framing error flag not set on low stop bit");

  ls_clr_a: assert property (@(posedge clk) disable iff (rst)
    ls_clear_s |=> !(st.brk || st.frm || st.par))
    else $error("line status flags not cleared by write");

  ls_irq_on_a: assert property (@(posedge clk) disable iff (rst)
    (ce && st.en_ls && (st.brk || st.frm || st.par)) |-> st.irq_ff)
    else $error("enabled line status flag without interrupt");

endmodule
`default_nettype wire

// ---- include/upis_pkg.sv ----
// Purpose: constants and types of the protocol interrupt and status block
// Assumes: 8-bit register byte address, 32-bit register data
// Notes: offsets are byte addresses on the plain register port
`default_nettype none
package upis_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_IRQ_EN = 8'h60;
  localparam logic [7:0] OFF_STATUS = 8'h64;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h68;
  localparam logic [7:0] OFF_CTRL = 8'h6C;
  localparam logic [7:0] OFF_BAUD = 8'h70;
  localparam int EN_LS_BIT = 2;
  localparam int EN_AB_BIT = 1;
  localparam int ST_CTS_PIN = 17;
  localparam int ST_CTS_SYNC = 16;
  localparam int ST_AB_ERR = 11;
  localparam int ST_BUSY = 10;
  localparam int ST_AB_DONE = 9;
  localparam int ST_BREAK = 7;
  localparam int ST_FRM = 6;
  localparam int ST_PAR = 5;
  localparam int CTL_STOP2 = 0;
  localparam int CTL_PAR_EN = 1;
  localparam int CTL_EVEN = 2;
  localparam int CTL_AB_EN = 6;
  localparam int BAUD_DIV_LSB = 16;
  localparam int BAUD_DIV_W = 10;
  localparam int AB_CNT_W = 12;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [BAUD_DIV_W-1:0] RST_BAUD_DIV = 10'h1B1;
  localparam logic [2:0] DATA_LAST = 3'h7;
  localparam logic [3:0] BASE_FRAME_BITS = 4'hA;
  localparam logic [2:0] AB_LAST_INTERVAL = 3'h3;

  typedef enum logic [2:0]
  {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100,
    RX_STOP2 = 3'b101
  } upis_rx_t;

  typedef enum logic [1:0]
  {
    AB_IDLE = 2'b00,
    AB_ARM = 2'b01,
    AB_MEAS = 2'b10
  } upis_ab_t;

  typedef struct packed
  {
    logic rx_s1;
    logic rx_s2;
    logic rx_prev;
    logic cts_s1;
    logic cts_lvl;
    logic cts_sync;
    logic en_ls;
    logic en_ab;
    logic stop2;
    logic par_en;
    logic even;
    logic ab_en;
    logic [BAUD_DIV_W-1:0] baud_div;
    upis_rx_t rx_state;
    logic [2:0] bit_cnt;
    logic [10:0] tick_cnt;
    logic par_acc;
    logic [15:0] low_cnt;
    upis_ab_t ab_state;
    logic [AB_CNT_W-1:0] ab_cnt;
    logic [2:0] ab_num;
    logic brk;
    logic frm;
    logic par;
    logic ab_done;
    logic ab_err;
    logic [31:0] rdata_ff;
    logic irq_ff;
  } upis_state_t;
endpackage
`default_nettype wire

// ---- test/upis_serial_peer.sv ----
// Purpose: remote serial sender driving the receive line and clear-to-send
// Assumes: bit time is given in clk cycles; the line idles high
// Notes: lines change by non-blocking assignment just after clk rises
`timescale 1ns/1ps
`default_nettype none
module upis_serial_peer
(
  input wire logic clk, // bench clock used for bit timing
  output logic rx_line, // serial data towards the block
  output logic cts_line // clear-to-send level
);
  initial
  begin
    rx_line = 1'b1;
    cts_line = 1'b0;
  end

  // holds the line at v for n cycles
  task automatic drive(input logic v, input int n);
    @(posedge clk);
    rx_line <= v;
    repeat (n - 1) @(posedge clk);
  endtask

  // one frame, lsb first, odd parity, then one idle bit time
  task automatic send(input logic [7:0] d, input int n, input logic par_on,
                      input logic par_bad, input logic stop_bad);
    drive(1'b0, n);
    for (int i = 0; i < 8; i++)
      drive(d[i], n);
    if (par_on)
      drive(~^d ^ par_bad, n);
    drive(~stop_bad, n);
    drive(1'b1, n);
  endtask

  task automatic set_cts(input logic v);
    @(posedge clk);
    cts_line <= v;
  endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Purpose: self-checking bench for the protocol interrupt and status block
// Assumes: register port with read data one cycle after the read strobe
// Notes: clock enable drops once to show that writes are then ignored
`timescale 1ns/1ps
`default_nettype none
module testbench
  import upis_pkg::*;
;
  logic clk;
  logic rst;
  logic ce;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic rx_line;
  logic cts_line;
  logic irq;
  int fail_count;
  int total_checks;
  int hits;
  logic [31:0] rd_word;

  upis_top upis_top_inst (.clk(clk), .rst(rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_line),
    .cts_pin(cts_line), .irq(irq));
  upis_serial_peer upis_serial_peer_inst (.clk(clk), .rx_line(rx_line),
    .cts_line(cts_line));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic chk_val(input string nm, input logic [31:0] e,
                         input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] a,
                         input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk_val(nm, e, d & m);
  endtask

  task automatic chk_irq(input logic e);
    #1;
    chk_val("irq", {31'h0, e}, {31'h0, irq});
  endtask

  // polls status until a bit of m is set, bounded
  task automatic wait_flag(input logic [31:0] m, input int lim,
                           output logic [31:0] d);
    for (int i = 0; i < lim; i++)
    begin
      rd(OFF_STATUS, d);
      if ((d & m) !== 32'h0)
        return;
    end
    fail_count++;
    $display("ERROR status wait expected %h seen %h", m, d);
    results();
  endtask

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fail_count = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    chk_reg("enable reset", OFF_IRQ_EN, 32'hFFFFFFFF, 32'h0);
    chk_reg("status reset", OFF_STATUS, 32'hFFFFFFFF, 32'h0);
    wr(OFF_IRQ_EN, 32'hFFFFFFFF);
    chk_reg("enable bits", OFF_IRQ_EN, 32'hFFFFFFFF, 32'h6);
    chk_reg("unmapped", 8'h7C, 32'hFFFFFFFF, 32'h0);
    chk_irq(1'b0);
    @(posedge clk);
    ce <= 1'b0;
    wr(OFF_IRQ_EN, 32'h0);
    ce <= 1'b1;
    chk_reg("ce freeze", OFF_IRQ_EN, 32'hFFFFFFFF, 32'h6);
    wr(OFF_IRQ_EN, 32'h0);
    for (int v = 1; v >= 0; v--)
    begin
      upis_serial_peer_inst.set_cts(v[0]);
      repeat (6) @(posedge clk);
      chk_reg("cts", OFF_STATUS, 32'h30000,
              {14'h0, v[0], v[0], 16'h0});
    end
    $display("test registers finished");

    wr(OFF_BAUD, 32'h0003_0000);
    fork
      upis_serial_peer_inst.send(8'hA5, 4, 1'b0, 1'b0, 1'b1);
      begin
        repeat (16) @(posedge clk);
        chk_reg("busy", OFF_STATUS, 32'h400, 32'h400);
      end
    join
    repeat (8) @(posedge clk);
    chk_reg("framing", OFF_STATUS, 32'hEE0, 32'h40);
    wr(OFF_IRQ_EN, 32'h2);
    chk_irq(1'b0);
    wr(OFF_IRQ_EN, 32'h4);
    chk_irq(1'b1);
    wr(OFF_STATUS, 32'h20);
    chk_reg("line clear", OFF_STATUS, 32'hE0, 32'h0);
    chk_irq(1'b0);
    // b[1] selects even parity; the peer sends odd parity, so flip it then
    for (int b = 0; b < 4; b++)
    begin
      wr(OFF_CTRL, {29'h0, b[1], 2'h2});
      upis_serial_peer_inst.send(8'h55, 4, 1'b1, b[0] ^ b[1], 1'b0);
      repeat (8) @(posedge clk);
      chk_reg("parity", OFF_STATUS, 32'hE0, {26'h0, b[0], 5'h0});
      chk_irq(b[0]);
      wr(OFF_IRQ_CLR, 32'h80);
      chk_reg("clear reg", OFF_STATUS, 32'hE0, 32'h0);
    end
    // two stop bits: break limit is 11 bit times, 44 cycles
    wr(OFF_CTRL, 32'h1);
    for (int k = 0; k < 2; k++)
    begin
      upis_serial_peer_inst.drive(1'b0, 42 + 18 * k);
      upis_serial_peer_inst.drive(1'b1, 8);
      repeat (4) @(posedge clk);
      chk_reg("break", OFF_STATUS, 32'h80, {24'h0, k[0], 7'h0});
      wr(OFF_STATUS, 32'h40);
      chk_reg("break clear", OFF_STATUS, 32'hE0, 32'h0);
    end
    $display("test line status finished");

    wr(OFF_IRQ_EN, 32'h2);
    wr(OFF_CTRL, 32'h40);
    hits = 0;
    fork
      upis_serial_peer_inst.send(8'h55, 16, 1'b0, 1'b0, 1'b0);
      for (int i = 0; i < 120; i++)
      begin
        rd(OFF_STATUS, rd_word);
        if (rd_word[ST_AB_DONE] === 1'b1)
        begin
          hits++;
          chk_irq(1'b1);
          wr(OFF_STATUS, 32'h200);
        end
      end
    join
    chk_val("done count", 32'h4, 32'(hits));
    chk_reg("detect off", OFF_CTRL, 32'h40, 32'h0);
    chk_reg("no overrun", OFF_STATUS, 32'hA00, 32'h0);
    for (int k = 0; k < 2; k++)
    begin
      wr(OFF_IRQ_EN, {30'h0, k[0], 1'b0});
      wr(OFF_BAUD, 32'h0003_0000);
      wr(OFF_CTRL, 32'h40);
      upis_serial_peer_inst.drive(1'b0, 8);
      upis_serial_peer_inst.drive(1'b1, 8);
      wait_flag(32'h200, 3000, rd_word);
      chk_val("overrun", 32'hA00, rd_word & 32'hA00);
      chk_irq(k[0]);
      wr(k[0] ? OFF_IRQ_CLR : OFF_STATUS,
         k[0] ? 32'h800 : 32'h200);
      // clearing only the error bit leaves the done flag standing
      chk_reg("overrun clear", OFF_STATUS, 32'hA00,
              k[0] ? 32'h200 : 32'h0);
    end
    $display("test auto-baud finished");
    results();
  end
endmodule
`default_nettype wire
